// [hdl/burst_timer.sv]
// Burst and pause timer for automatic transmit tone bursts.
`timescale 1ns/100ps
`default_nettype none
module burst_timer
  import dtmf_pkg::*;
#(
  parameter int CYCLES = 5100000,
  parameter int CNT_W  = 24
) (
  // Clock, reset and enable.
  input  wire logic ref_clk_in,
  input  wire logic rstn_in,
  input  wire logic clk_en_in,
  // Control.
  input  wire logic start_in,
  input  wire logic abort_in,
  input  wire logic long_in,
  // Results.
  output logic      tone_on_out,
  output logic      done_out
);

  // Elaboration check: both phases of a call-progress burst must fit the counter.
  if (CYCLES < 1 || (64'(CYCLES) * 64'd2) >= (64'd1 << CNT_W)) begin : g_bad_cycles
    $error("burst_timer: CYCLES does not fit the counter");
  end

  burst_state_t     state_r;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] len;

  // Call-progress mode doubles both burst and pause.
  assign len = long_in ? CNT_W'(CYCLES * 2) : CNT_W'(CYCLES);

  // A new start restarts the burst so the latest digit gets full length.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r  <= BURST_IDLE;
      count_r  <= '0;
      done_out <= 1'b0;
    end else if (clk_en_in) begin
      done_out <= 1'b0;
      if (abort_in) begin
        state_r <= BURST_IDLE;
        count_r <= '0;
      end else if (start_in) begin
        state_r <= BURST_TONE;
        count_r <= len - CNT_W'(1);
      end else begin
        unique case (state_r)
          BURST_IDLE: count_r <= '0;
          BURST_TONE: begin
            if (count_r == '0) begin
              state_r <= BURST_PAUSE;
              count_r <= len - CNT_W'(1);
            end else begin
              count_r <= count_r - CNT_W'(1);
            end
          end
          BURST_PAUSE: begin
            if (count_r == '0) begin
              state_r  <= BURST_IDLE;
              done_out <= 1'b1;
            end else begin
              count_r <= count_r - CNT_W'(1);
            end
          end
          default: state_r <= BURST_IDLE;
        endcase
      end
    end
  end

  assign tone_on_out = (state_r == BURST_TONE);

endmodule : burst_timer
`default_nettype wire

// [hdl/dtmf_host_regs.sv]
// Host register bank and control logic of the tone transceiver.
`timescale 1ns/100ps
`default_nettype none
`include "dtmf_regs.svh"
module dtmf_host_regs
  import dtmf_pkg::*;
#(
  parameter int BURST_CYCLES = int'(`BURST_CYCLES),
  parameter int CNT_W        = 24
) (
  // Clock, reset and enable.
  input  wire logic       ref_clk_in,
  input  wire logic       rstn_in,
  input  wire logic       clk_en_in,
  // Host strobed bus, select and strobes active low; the data output enable is active high.
  input  wire logic       chip_select_n_in,
  input  wire logic       register_select_line_in,
  input  wire logic       wr_n_in,
  input  wire logic       rd_n_in,
  input  wire logic [3:0] data_in,
  output logic      [3:0] data_out,
  output logic            data_oe_out,
  // Receiver core.
  input  wire logic       rx_digit_valid_in,
  input  wire logic [3:0] rx_digit_code_in,
  input  wire logic       steering_delayed_in,
  input  wire logic       cp_tone_in,
  // Transmit generator.
  output logic      [3:0] tx_code_out,
  output logic            tone_enable_out,
  output logic            single_tone_out,
  output logic            column_tone_out,
  output logic            cp_mode_out,
  // Shared open-drain event or tone pin.
  input  wire logic       event_or_tone_out_pin_in,
  output logic            event_or_tone_out_pin_out,
  output logic            event_or_tone_out_pin_oe_out
);

  // Bus timing in short: an access is decoded on every enabled edge while the
  // select is low and exactly one strobe is low. The decoded kind is kept for one
  // clock, and the edge that first sees the strobe high again commits a write or
  // clears the shown status bits. This costs one clock after the strobe, but a
  // strobe that is broken by the other strobe is simply dropped and never half-done.
  // Read data come from a flip-flop loaded on each edge of the read, so from the
  // first edge of the strobe on the bus carries settled data.
  // The host bus has no ready line; any strobe of at least one clock low and one
  // clock high in between is served.

  // Elaboration checks: the counter width must suit the burst timer.
  if (CNT_W < 2 || CNT_W > 31) begin : g_bad_cnt_w
    $error("dtmf_host_regs: CNT_W out of range");
  end
  if (BURST_CYCLES < 1) begin : g_bad_burst
    $error("dtmf_host_regs: BURST_CYCLES must be at least one");
  end

  // Reset brings every register to zero. The host still runs its own init sequence,
  // since nothing tells it whether the block was reset before its program started.

  // Register state.
  logic [3:0] primary_control_r;
  logic [3:0] secondary_control_r;
  logic [3:0] tx_digit_r;
  logic [3:0] rx_digit_r;
  logic [3:0] status_r;
  logic       target_secondary_r;

  // The access kind seen at the previous edge; its end is what commits or clears.
  // Bus tracking state.
  access_t    access_q_r;
  logic [3:0] wr_data_r;
  logic [3:0] read_shown_r;
  logic [3:0] data_out_r;

  // Decode results.
  access_t    access_now;
  logic       write_end;
  logic       read_end;
  logic       write_digit;
  logic       write_ctrl;
  logic       read_status_end;

  // Control field views.
  logic       tone_en;
  logic       cp_mode;
  logic       irq_en;
  logic       burst_on;
  logic       test_mode;

  // Burst timer links.
  logic       burst_tone;
  logic       burst_done;

  // Status flag events.
  logic       set_rx_full;
  logic       set_tx_empty;
  logic [3:0] flag_clear;
  logic [3:0] flag_set;

  // Pin drive decision.
  logic       pull_low;

  // Named views of the control fields; the target bit of the primary register has
  // no view, since it only feeds the one-shot target flag below.
  // Bit 0 of the secondary register is active low: a clear bit means bursts on.
  assign tone_en   = primary_control_r[`PRI_TONE_EN_BIT];
  assign cp_mode   = primary_control_r[`PRI_CP_MODE_BIT];
  assign irq_en    = primary_control_r[`PRI_IRQ_EN_BIT];
  assign burst_on  = ~secondary_control_r[`SEC_BURST_OFF_BIT];
  assign test_mode = secondary_control_r[`SEC_TEST_BIT];

  // Decode one access per cycle; overlapping strobes or no select count as none.
  // Treating both strobes low as no access keeps a glitching host from writing and
  // reading in one cycle.
  // The select level picks the register pair; the write strobe picks the direction.
  always_comb begin
    access_now = ACC_NONE;
    if (!chip_select_n_in && (wr_n_in ^ rd_n_in)) begin
      unique case ({register_select_line_in, wr_n_in})
        {`SEL_DIGIT, 1'b0}: access_now = ACC_WR_DIGIT;
        {`SEL_DIGIT, 1'b1}: access_now = ACC_RD_DIGIT;
        {`SEL_CTRL, 1'b0}:  access_now = ACC_WR_CTRL;
        {`SEL_CTRL, 1'b1}:  access_now = ACC_RD_STATUS;
      endcase
    end
  end

  // An access takes effect when its strobe ends, so the host sees stable data all cycle.
  // A strobe broken by a second strobe is dropped, not committed.
  assign write_end   = (access_q_r == ACC_WR_DIGIT || access_q_r == ACC_WR_CTRL) &&
                       (access_now == ACC_NONE) && wr_n_in;
  assign read_end    = (access_q_r == ACC_RD_DIGIT || access_q_r == ACC_RD_STATUS) &&
                       (access_now == ACC_NONE) && rd_n_in;
  assign write_digit     = write_end && (access_q_r == ACC_WR_DIGIT);
  assign write_ctrl      = write_end && (access_q_r == ACC_WR_CTRL);
  assign read_status_end = read_end && (access_q_r == ACC_RD_STATUS);

  // Track the access in progress and hold the written nibble while the strobe is low.
  // The nibble is refreshed on every edge of the write, so the value that commits is
  // the one the host held last.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      access_q_r <= ACC_NONE;
      wr_data_r  <= 4'h0;
    end else if (clk_en_in) begin
      access_q_r <= access_now;
      if (access_now == ACC_WR_DIGIT || access_now == ACC_WR_CTRL) begin
        wr_data_r <= data_in;
      end
    end
  end

  // Transmit digit register; it has no read path at all.
  // Nothing on the host side can read it back, so a host must keep its own copy.
  // A write during a burst replaces the code at once and restarts the burst.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_digit_r <= `DIGIT_RESET;
    end else if (clk_en_in && write_digit) begin
      tx_digit_r <= wr_data_r;
    end
  end

  // Both control registers share one address; a one-shot flag picks the target.
  // The flag is a hazard for hosts that lose track of it: the init sequence writes
  // the primary register twice with bit 3 low before it sets it, so any stale flag
  // is used up by the first of those writes.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      primary_control_r   <= `CTRL_RESET;
      secondary_control_r <= `CTRL_RESET;
      target_secondary_r  <= 1'b0;
    end else if (clk_en_in && write_ctrl) begin
      if (target_secondary_r) begin
        secondary_control_r <= wr_data_r;
        target_secondary_r  <= 1'b0;
      end else begin
        primary_control_r  <= wr_data_r;
        target_secondary_r <= wr_data_r[`PRI_TARGET_SEC_BIT];
      end
    end
  end

  // Received digit holds until a newer valid digit; ignored in call-progress mode.
  // A digit arriving in the cycle of a mode change is judged by the old mode,
  // because the mode register only moves at the end of the write strobe.
  // The status flags are raised by the same pulse at the same edge as the code.
  assign set_rx_full = rx_digit_valid_in && !cp_mode;

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_digit_r <= `DIGIT_RESET;
    end else if (clk_en_in && set_rx_full) begin
      rx_digit_r <= rx_digit_code_in;
    end
  end

  // Automatic burst timing runs only with burst mode on and tone output enabled.
  // Clearing either enable aborts the timer, so a host that turns tones off in
  // mid-burst gets silence and no transmit-empty event later.
  // The timer runs from the same enable, so holding the clock enable low stretches
  // the burst; hosts that gate the enable must allow for that.
  burst_timer #(
    .CYCLES (BURST_CYCLES),
    .CNT_W  (CNT_W)
  ) u_burst (
    .ref_clk_in  (ref_clk_in),
    .rstn_in     (rstn_in),
    .clk_en_in   (clk_en_in),
    .start_in    (write_digit && burst_on && tone_en),
    .abort_in    (!burst_on || !tone_en),
    .long_in     (cp_mode),
    .tone_on_out (burst_tone),
    .done_out    (burst_done)
  );

  // A finished burst only counts while burst mode is still on.
  assign set_tx_empty = burst_done && burst_on;

  // Flag updates; a read clears only bits it actually showed, and a set wins.
  // Clearing only the shown bits means an event that lands during the read is kept
  // for the next read instead of being lost.
  // Bit 3 is not a sticky flag and never takes part in the clear.
  // Leaving burst mode clears the transmit-empty flag, which has no meaning there.
  // The interrupt flag is set by either event and cleared only by a status read.
  always_comb begin
    flag_set   = 4'h0;
    flag_clear = 4'h0;
    flag_set[`ST_RX_FULL_BIT]  = set_rx_full;
    flag_set[`ST_TX_EMPTY_BIT] = set_tx_empty;
    flag_set[`ST_IRQ_BIT]      = set_rx_full || set_tx_empty;
    if (read_status_end) begin
      flag_clear = read_shown_r;
    end
    flag_clear[`ST_STEER_BIT] = 1'b0;
    if (!burst_on) begin
      flag_clear[`ST_TX_EMPTY_BIT] = 1'b1;
    end
  end

  // Sticky status flags; the steering bit mirrors the receiver's delayed steering.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_r <= 4'h0;
    end else if (clk_en_in) begin
      status_r[2:0] <= (status_r[2:0] & ~flag_clear[2:0]) | flag_set[2:0];
      status_r[`ST_STEER_BIT] <= steering_delayed_in;
    end
  end

  // Read data is refreshed each cycle of a read and held as shown for the clear.
  // Only the last edge of a status read decides which bits get cleared, matching the
  // value the host latched at the end of its strobe.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      data_out_r   <= 4'h0;
      read_shown_r <= 4'h0;
    end else if (clk_en_in) begin
      if (access_now == ACC_RD_DIGIT) begin
        data_out_r <= rx_digit_r;
      end else if (access_now == ACC_RD_STATUS) begin
        data_out_r   <= status_r;
        read_shown_r <= status_r;
      end
    end
  end

  // Bus driven only during a clean read; one clock of latency fits any 16 MHz cycle.
  // The enable is combinational so the bus is released as soon as the strobe rises;
  // a registered enable would hold the bus a clock into the host's next cycle.
  assign data_out    = data_out_r;
  assign data_oe_out = (access_now == ACC_RD_DIGIT) || (access_now == ACC_RD_STATUS);

  // Tone output: bit 0 gates the tone enable; in burst mode only the burst phase sounds.
  // With burst mode off the host times tones itself by toggling bit 0.
  assign tone_enable_out = tone_en && (burst_on ? burst_tone : 1'b1);
  assign tx_code_out     = tx_digit_r;
  assign single_tone_out = secondary_control_r[`SEC_SINGLE_BIT];
  assign column_tone_out = secondary_control_r[`SEC_COLUMN_BIT];
  assign cp_mode_out     = cp_mode;

  // Shared pin: squared tone, steering test view or interrupt, low level only.
  // Call-progress mode takes priority: no digit events are raised in that mode, so
  // the squared tone is not mixed up with a digit interrupt.
  // In test mode the pin follows the delayed steering level, which shows the guard
  // timing without the interrupt flags getting in the way.
  always_comb begin
    pull_low = 1'b0;
    if (cp_mode) begin
      if (irq_en) begin
        pull_low = !cp_tone_in;
      end
    end else if (test_mode) begin
      pull_low = !status_r[`ST_STEER_BIT];
    end else if (irq_en) begin
      pull_low = status_r[`ST_IRQ_BIT];
    end
  end

  // Open drain: the output level is always low and only the enable moves.
  // The pin's read-back is not used inside; it is kept for board-level checks.
  assign event_or_tone_out_pin_out    = 1'b0;
  assign event_or_tone_out_pin_oe_out = pull_low;

endmodule : dtmf_host_regs
`default_nettype wire

// [hdl/dtmf_pkg.sv]
// Types shared by the tone transceiver host register block.
`default_nettype none
package dtmf_pkg;

  // Phases of one automatic transmit burst.
  typedef enum logic [1:0] {
    BURST_IDLE,
    BURST_TONE,
    BURST_PAUSE
  } burst_state_t;

  // Kind of bus access decoded from select and strobes.
  typedef enum logic [2:0] {
    ACC_NONE,
    ACC_WR_DIGIT,
    ACC_RD_DIGIT,
    ACC_WR_CTRL,
    ACC_RD_STATUS
  } access_t;

endpackage : dtmf_pkg
`default_nettype wire

// [hdl/dtmf_regs.svh]
// Constants of the tone transceiver host register block: selects, bit positions, resets, timing.
`ifndef DTMF_REGS_SVH
`define DTMF_REGS_SVH

// Register select levels.
`define SEL_DIGIT           1'b0
`define SEL_CTRL            1'b1

// Primary control field positions.
`define PRI_TONE_EN_BIT     0
`define PRI_CP_MODE_BIT     1
`define PRI_IRQ_EN_BIT      2
`define PRI_TARGET_SEC_BIT  3

// Secondary control field positions.
`define SEC_BURST_OFF_BIT   0
`define SEC_TEST_BIT        1
`define SEC_SINGLE_BIT      2
`define SEC_COLUMN_BIT      3

// Status field positions.
`define ST_IRQ_BIT          0
`define ST_TX_EMPTY_BIT     1
`define ST_RX_FULL_BIT      2
`define ST_STEER_BIT        3

// Reset values.
`define CTRL_RESET          4'h0
`define DIGIT_RESET         4'h0

// Burst timing: 51 ms at a 100 MHz clock.
`define CLK_FREQ_HZ         64'd100000000
`define BURST_TIME_MS       64'd51
`define BURST_CYCLES        ((`BURST_TIME_MS * `CLK_FREQ_HZ) / 64'd1000)

`endif

// [tb/dtmf_host_regs_asserts.sv]
// Port checker of the host register block.
`timescale 1ns/100ps
`default_nettype none
module dtmf_host_regs_asserts (
  // Clock and reset.
  input wire logic       ref_clk_in,
  input wire logic       rstn_in,
  input wire logic       clk_en_in,
  // Host bus.
  input wire logic       chip_select_n_in,
  input wire logic       register_select_line_in,
  input wire logic       wr_n_in,
  input wire logic       rd_n_in,
  input wire logic [3:0] data_in,
  input wire logic [3:0] data_out,
  input wire logic       data_oe_out,
  // Receiver and generator.
  input wire logic       rx_digit_valid_in,
  input wire logic [3:0] rx_digit_code_in,
  input wire logic       cp_tone_in,
  input wire logic [3:0] tx_code_out,
  input wire logic       tone_enable_out,
  input wire logic       single_tone_out,
  input wire logic       column_tone_out,
  input wire logic       cp_mode_out,
  // Shared pin.
  input wire logic       event_or_tone_out_pin_out,
  input wire logic       event_or_tone_out_pin_oe_out
);
  logic       wr_q, rs_q, sec_sel_r;
  logic [3:0] d_q, pri_r, sec_r, tx_r, rx_r;
  wire        rd_dig = !chip_select_n_in && !rd_n_in && wr_n_in && !register_select_line_in;
  wire        commit = wr_q && wr_n_in;

  // Shadow of the write path; it freezes with the clock enable like the design.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      {wr_q, rs_q, sec_sel_r, d_q, pri_r, sec_r, tx_r} <= '0;
    end else if (clk_en_in) begin
      wr_q <= !chip_select_n_in && !wr_n_in && rd_n_in;
      rs_q <= register_select_line_in;
      d_q  <= data_in;
      if (commit && !rs_q) tx_r <= d_q;
      if (commit && rs_q && sec_sel_r) sec_r <= d_q;
      if (commit && rs_q && !sec_sel_r) pri_r <= d_q;
      if (commit && rs_q) sec_sel_r <= !sec_sel_r && d_q[3];
    end
  end

  // Shadow of the received digit; call-progress mode hides digits.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_r <= '0;
    end else if (clk_en_in && rx_digit_valid_in && !cp_mode_out) begin
      rx_r <= rx_digit_code_in;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  AST_READ_DRIVE: assert property (data_oe_out == (!chip_select_n_in && !rd_n_in && wr_n_in))
    else $error("data bus drive does not follow a clean read");
  AST_RX_READ: assert property (rd_dig && $past(rd_dig) |-> data_out == $past(rx_r))
    else $error("digit read shows wrong code");
  AST_TX_LOAD: assert property (tx_code_out == tx_r)
    else $error("transmit code differs from last digit write");
  AST_CP_MODE: assert property (cp_mode_out == pri_r[1])
    else $error("mode output differs from primary control");
  AST_SEC_FIELDS: assert property ({column_tone_out, single_tone_out} == sec_r[3:2])
    else $error("tone fields differ from secondary control");
  AST_TONE_GATE: assert property (!pri_r[0] |-> !tone_enable_out)
    else $error("tone on while gated off");
  AST_CP_PIN: assert property (pri_r[1] && pri_r[2] |-> event_or_tone_out_pin_oe_out == !cp_tone_in)
    else $error("pin does not follow squared tone");
  AST_PIN_QUIET: assert property (!pri_r[2] && !sec_r[1] |-> !event_or_tone_out_pin_oe_out)
    else $error("pin pulled with events off");
  AST_OPEN_DRAIN: assert property (event_or_tone_out_pin_out == 1'b0)
    else $error("pin driven high");
endmodule : dtmf_host_regs_asserts
`default_nettype wire

// [tb/host_model.sv]
// Host microcontroller model on the strobed register bus.
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // Clock.
  input  wire logic       ref_clk_in,
  // Strobed bus.
  output logic            chip_select_n_out,
  output var logic        register_select_line_out,
  output var logic        wr_n_out,
  output var logic        rd_n_out,
  output var logic  [3:0] data_out,
  input  wire logic [3:0] data_in
);
  logic ale_r, decode_r;

  // Select is the NAND of address latch and page decode, as a multiplexed host makes it.
  assign chip_select_n_out = ~(ale_r & decode_r);

  // Bus idles deselected with both strobes high.
  initial begin
    {ale_r, register_select_line_out, data_out} = '0;
    {decode_r, wr_n_out, rd_n_out} = '1;
  end

  // One cycle: strobes held two edges, released an edge before deselect.
  // No ready line exists, so the host never stretches a cycle.
  task automatic access(input logic rs, input logic wn, input logic rn,
                        input logic [3:0] d, output logic [3:0] q);
    @(negedge ref_clk_in);
    ale_r = 1'b1;
    register_select_line_out = rs;
    wr_n_out = wn;
    rd_n_out = rn;
    data_out = wn ? ~data_out : d;
    repeat (2) @(posedge ref_clk_in);
    // Read data are taken where they have settled, before the strobe is released.
    @(negedge ref_clk_in);
    q = data_in;
    wr_n_out = 1'b1;
    rd_n_out = 1'b1;
    @(negedge ref_clk_in);
    ale_r = 1'b0;
    data_out = ~data_out;
  endtask : access
endmodule : host_model
`default_nettype wire

// [tb/tb_top.sv]
// Top bench of the host register block with host model and checker.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct packed {logic rs; logic rd; logic [3:0] d; logic [7:0] exp;} row_t;
  logic       ref_clk_in, rstn_in, cs_n, rs, wr_n, rd_n, rx_valid, cp_tone, clk_en, steer;
  logic       dev_oe, tone_en, single, column, cp_mode, pin_o, pin_oe;
  logic [3:0] host_d, dev_d, rx_code, tx_code, q;
  int         n_errors, n_compared, k;
  row_t       rows [13];
  // Pull-up on the shared pin.
  wire        pin = pin_oe ? pin_o : 1'b1;

  dtmf_host_regs #(.BURST_CYCLES(20), .CNT_W(24)) dut_u (
    .ref_clk_in, .rstn_in, .clk_en_in(clk_en), .chip_select_n_in(cs_n),
    .register_select_line_in(rs), .wr_n_in(wr_n), .rd_n_in(rd_n), .data_in(host_d),
    .data_out(dev_d), .data_oe_out(dev_oe), .rx_digit_valid_in(rx_valid),
    .rx_digit_code_in(rx_code), .steering_delayed_in(steer), .cp_tone_in(cp_tone),
    .tx_code_out(tx_code), .tone_enable_out(tone_en), .single_tone_out(single),
    .column_tone_out(column), .cp_mode_out(cp_mode), .event_or_tone_out_pin_in(pin),
    .event_or_tone_out_pin_out(pin_o), .event_or_tone_out_pin_oe_out(pin_oe));
  // The host sees the inverse of the last value whenever the device is not driving.
  host_model host_u (.ref_clk_in, .chip_select_n_out(cs_n), .register_select_line_out(rs),
    .wr_n_out(wr_n), .rd_n_out(rd_n), .data_out(host_d),
    .data_in(dev_oe ? dev_d : ~dev_d));

  // Clock of 10 ns period.
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  // Comparison and verdict.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic acc(input logic r, input logic wn, input logic rn, input logic [3:0] d);
    host_u.access(r, wn, rn, d, q);
  endtask : acc
  // One-cycle digit pulse; the code line then shows garbage.
  task automatic pulse(input logic [3:0] c);
    @(negedge ref_clk_in);
    rx_valid = 1'b1;
    rx_code  = c;
    @(negedge ref_clk_in);
    rx_valid = 1'b0;
    rx_code  = ~c;
  endtask : pulse

  // Hang guard.
  initial begin
    repeat (5000) @(posedge ref_clk_in);
    n_errors++;
    conclude();
  end

  // Init sequence, then receive, call progress, burst, steering, enable and reset; write rows check {tx, col, single, cp, tone}.
  initial begin
    {rstn_in, rx_valid, cp_tone, steer, rx_code} = '0;
    clk_en = 1'b1;
    n_errors = 0;
    n_compared = 0;
    rows = '{{2'b11, 4'h0, 8'h00}, {2'b10, 4'h0, 8'h00}, {2'b10, 4'h0, 8'h00},
             {2'b10, 4'h8, 8'h00}, {2'b10, 4'h0, 8'h00}, {2'b11, 4'h0, 8'h00},
             {2'b10, 4'h8, 8'h00}, {2'b10, 4'hd, 8'h0c}, {2'b10, 4'h3, 8'h0f},
             {2'b00, 4'h5, 8'h5f}, {2'b10, 4'h1, 8'h5d}, {2'b10, 4'h0, 8'h5c},
             {2'b01, 4'h0, 8'h00}};
    repeat (16) @(negedge ref_clk_in);
    rstn_in = 1'b1;
    foreach (rows[i]) begin
      acc(rows[i].rs, rows[i].rd, !rows[i].rd, rows[i].d);
      chk(rows[i].rd ? {4'h0, q} : {tx_code, column, single, cp_mode, tone_en}, rows[i].exp);
    end
    $display("test table done");
    acc(1'b1, 1'b0, 1'b1, 4'h4);
    pulse(4'ha);
    chk({6'h0, pin_oe, pin}, 8'h02);
    acc(1'b0, 1'b1, 1'b0, 4'h0);
    chk({4'h0, q}, 8'h0a);
    acc(1'b1, 1'b1, 1'b0, 4'h0);
    chk({4'h0, q}, 8'h05);
    chk({7'h0, pin_oe}, 8'h00);
    acc(1'b1, 1'b1, 1'b0, 4'h0);
    chk({4'h0, q}, 8'h00);
    $display("test receive done");
    acc(1'b1, 1'b0, 1'b1, 4'h6);
    pulse(4'h3);
    acc(1'b0, 1'b1, 1'b0, 4'h0);
    chk({4'h0, q}, 8'h0a);
    acc(1'b1, 1'b1, 1'b0, 4'h0);
    chk({4'h0, q}, 8'h00);
    cp_tone = 1'b1;
    #1 chk({7'h0, pin_oe}, 8'h00);
    @(negedge ref_clk_in) cp_tone = 1'b0;
    #1 chk({7'h0, pin_oe}, 8'h01);
    acc(1'b1, 1'b0, 1'b0, 4'hf);
    chk({6'h0, cp_mode, tone_en}, 8'h02);
    $display("test call progress done");
    acc(1'b1, 1'b0, 1'b1, 4'hd);
    acc(1'b1, 1'b0, 1'b1, 4'h0);
    acc(1'b0, 1'b0, 1'b1, 4'h7);
    chk({tx_code, 3'h0, tone_en}, 8'h71);
    k = 0;
    while (!pin_oe && k < 200) begin
      @(negedge ref_clk_in);
      k++;
    end
    if (k >= 200) begin
      n_errors++;
    end
    chk({7'h0, k > 30}, 8'h01);
    chk({7'h0, tone_en}, 8'h00);
    acc(1'b1, 1'b1, 1'b0, 4'h0);
    chk({4'h0, q}, 8'h03);
    $display("test burst done");
    // Test mode: the pin follows the delayed steering level, shown in status bit 3.
    acc(1'b1, 1'b0, 1'b1, 4'hc);
    acc(1'b1, 1'b0, 1'b1, 4'h2);
    chk({6'h0, pin_oe, pin}, 8'h02);
    steer = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    chk({6'h0, pin_oe, pin}, 8'h01);
    acc(1'b1, 1'b1, 1'b0, 4'h0);
    chk({4'h0, q}, 8'h08);
    $display("test steering done");
    // A write while the clock enable is low must not land.
    clk_en = 1'b0;
    acc(1'b1, 1'b0, 1'b1, 4'h3);
    chk({6'h0, cp_mode, tone_en}, 8'h00);
    clk_en = 1'b1;
    acc(1'b1, 1'b0, 1'b1, 4'h3);
    chk({6'h0, cp_mode, tone_en}, 8'h02);
    $display("test enable done");
    // Reset in mid-run, then an access at once after the release.
    rstn_in = 1'b0;
    repeat (2) @(negedge ref_clk_in);
    chk({tx_code, column, single, cp_mode, tone_en}, 8'h00);
    rstn_in = 1'b1;
    acc(1'b1, 1'b1, 1'b0, 4'h0);
    chk({4'h0, q}, 8'h08);
    $display("test reset done");
    conclude();
  end
endmodule : tb_top

bind dtmf_host_regs dtmf_host_regs_asserts chk_u (.ref_clk_in, .rstn_in, .clk_en_in,
  .chip_select_n_in,
  .register_select_line_in, .wr_n_in, .rd_n_in, .data_in, .data_out, .data_oe_out,
  .rx_digit_valid_in, .rx_digit_code_in, .cp_tone_in, .tx_code_out, .tone_enable_out,
  .single_tone_out, .column_tone_out, .cp_mode_out, .event_or_tone_out_pin_out,
  .event_or_tone_out_pin_oe_out);
`default_nettype wire
